// File: src/bus_wake_ctrl.sv
// Purpose: bus transceiver and wake source control registers
// Assumes: serial front end delivers one decoded access per frame end
// Notes:   fail-safe entry and restart are single-cycle pulses
`timescale 1ns/10ps
`default_nettype none

// How it works
// [R1] flash bit 1 turns off serial bus slope control, up to 115 kBaud
// [R2] low-slope bit 1 selects 10.4 kBaud low-slope mode, else normal
// [R3] tx timeout feature follows the timeout-enable bit
// [R4] first serial bus mode at bits 4:3; device may overwrite it
// [R5] CAN mode at bits 1:0; device may overwrite it
// [R6] reserved bits always read zero
// [R7] option bits act at chip select release, for both serial buses
// [R8] fail-safe entry forces wake-capable values into three registers
// [R9] peak bit selects low (0) or high (1) regulator peak threshold
// [R10] peak bit writable in init and normal; stop write silently ignored
// [R11] second serial bus mode at bits 1:0 of bus control b
// [R12] timer b wakes only while its enable bit is set
// [R13] timer a wakes only while its enable bit is set
// [R14] stop watchdog disable bit; device may update it
// [R15] global bit 0: only wakes interrupt; 1: all status interrupts
// [R16] measurement select disables wake inputs a and b
// [R17] measurement runs in normal mode; a/b level status disregarded
// [R18] enable bits 2..0 enable wake inputs c, b, a
// [R19] host sets modes to wake capable to use buses as wake sources
// [R20] restart keeps upper options, clears bit 2, loads cause-based modes
// [R21] writes to reserved bits are ignored
module bus_wake_ctrl (
  input  wire logic                     clock_i,
  input  wire logic                     rstn_i,
  input  wire logic                     soft_reset_i,
  // access from the serial front end, presented at chip select release
  input  wire logic                     wr_i,
  input  wire logic [6:0]               addr_i,
  input  wire logic [7:0]               wdata_i,
  output logic      [7:0]               rdata_o,
  output logic                          addr_hit_o,
  output logic                          write_fail_o,
  // device-side updates
  input  wire bus_wake_pkg::dev_mode_t  dev_mode_i,
  input  wire logic                     failsafe_entry_i,
  input  wire logic                     restart_i,
  input  wire logic [1:0]               restart_ser_a_mode_i,
  input  wire logic [1:0]               restart_can_mode_i,
  input  wire logic [1:0]               restart_ser_b_mode_i,
  input  wire logic                     hw_ser_a_we_i,
  input  wire logic [1:0]               hw_ser_a_mode_i,
  input  wire logic                     hw_can_we_i,
  input  wire logic [1:0]               hw_can_mode_i,
  input  wire logic                     hw_ser_b_we_i,
  input  wire logic [1:0]               hw_ser_b_mode_i,
  input  wire logic                     hw_wd_dis_we_i,
  input  wire logic                     hw_wd_dis_i,
  // wake and interrupt sources
  input  wire logic                     timer_a_event_i,
  input  wire logic                     timer_b_event_i,
  input  wire logic [2:0]               wake_input_event_i,
  input  wire logic [2:0]               wake_level_i,
  input  wire logic                     status_event_i,
  // control outputs
  output logic                          slope_control_off_o,
  output logic                          low_slope_select_o,
  output logic                          tx_timeout_enable_o,
  output logic      [1:0]               first_serial_bus_mode_o,
  output logic      [1:0]               second_serial_bus_mode_o,
  output logic      [1:0]               can_mode_o,
  output logic                          peak_current_threshold_select_o,
  output logic                          stop_watchdog_disable_hi_o,
  output logic                          measure_active_o,
  output logic      [2:0]               wake_level_valid_o,
  output logic                          timer_wake_o,
  output logic                          input_wake_o,
  output logic                          interrupt_request_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] bus_a;
    logic [7:0] bus_b;
    logic [7:0] wake_i;
    logic [7:0] wake_e;
    logic [7:0] rdata;
    logic       hit;
    logic       fail;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  logic       wr_a;
  logic       wr_b;
  logic       wr_i_reg;
  logic       wr_e;
  logic       peak_ok;
  logic [7:0] mask_b;
  logic [7:0] peak_bit;

  assign peak_bit = 8'h01 << bus_wake_pkg::BIT_PEAK;

  assign wr_a = wr_i && (addr_i == bus_wake_pkg::ADDR_BUS_A);
  assign wr_b = wr_i && (addr_i == bus_wake_pkg::ADDR_BUS_B);
  assign wr_i_reg = wr_i && (addr_i == bus_wake_pkg::ADDR_WAKE_I);
  assign wr_e = wr_i && (addr_i == bus_wake_pkg::ADDR_WAKE_E);
  assign peak_ok = (dev_mode_i == bus_wake_pkg::DEV_INIT) ||
                   (dev_mode_i == bus_wake_pkg::DEV_NORMAL); // see [R10]
  assign mask_b = peak_ok ? bus_wake_pkg::MASK_BUS_B
                          : (bus_wake_pkg::MASK_BUS_B & ~peak_bit); // see [R10]

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.fail = 1'b0;
    // host writes: only defined bits are stored
    if (wr_a) begin
      s_d.bus_a = merge(s_q.bus_a, wdata_i, bus_wake_pkg::MASK_BUS_A); // see [R21] see [R7]
    end
    if (wr_b) begin
      s_d.bus_b = merge(s_q.bus_b, wdata_i, mask_b); // see [R21] see [R10]
    end
    if (wr_i_reg) begin
      s_d.wake_i = merge(s_q.wake_i, wdata_i, bus_wake_pkg::MASK_WAKE_I); // see [R21]
    end
    if (wr_e) begin
      s_d.wake_e = merge(s_q.wake_e, wdata_i, bus_wake_pkg::MASK_WAKE_E); // see [R21]
    end
    // device updates win over a host write in the same cycle
    if (hw_ser_a_we_i) begin
      s_d.bus_a[bus_wake_pkg::POS_SER_A +: 2] = hw_ser_a_mode_i; // see [R4]
    end
    if (hw_can_we_i) begin
      s_d.bus_a[bus_wake_pkg::POS_CAN +: 2] = hw_can_mode_i; // see [R5]
    end
    if (hw_ser_b_we_i) begin
      s_d.bus_b[bus_wake_pkg::POS_SER_B +: 2] = hw_ser_b_mode_i; // see [R11]
    end
    if (hw_wd_dis_we_i) begin
      s_d.wake_i[bus_wake_pkg::BIT_WD_DIS_HI] = hw_wd_dis_i; // see [R14]
    end
    if (restart_i) begin
      s_d.bus_a = (s_q.bus_a & bus_wake_pkg::RS_KEEP_A)
                | {3'h0, restart_ser_a_mode_i, 1'b0, restart_can_mode_i}; // see [R20]
      s_d.bus_b = {6'h0, restart_ser_b_mode_i} | (s_q.bus_b & peak_bit);
    end
    // fail-safe wins over host, device and restart updates, only soft reset overrides it: device must stay wakeable
    if (failsafe_entry_i) begin
      s_d.bus_a = (s_q.bus_a & bus_wake_pkg::FS_KEEP_A) | bus_wake_pkg::FS_BUS_A; // see [R8]
      s_d.bus_b = bus_wake_pkg::FS_BUS_B; // see [R8]
      s_d.wake_e = (s_q.wake_e & bus_wake_pkg::FS_KEEP_E) | bus_wake_pkg::FS_WAKE_E; // see [R8]
    end
    // soft reset last, so read data shows the reset values at once
    if (soft_reset_i) begin
      s_d.bus_a = bus_wake_pkg::RST_BUS_A;
      s_d.bus_b = bus_wake_pkg::RST_BUS_B;
      s_d.wake_i = bus_wake_pkg::RST_WAKE_I;
      s_d.wake_e = bus_wake_pkg::RST_WAKE_E;
    end
    // read back; reserved bits are zero in storage already
    s_d.hit = 1'b1;
    unique case (addr_i)
      bus_wake_pkg::ADDR_BUS_A:  s_d.rdata = s_d.bus_a & bus_wake_pkg::MASK_BUS_A; // see [R6]
      bus_wake_pkg::ADDR_BUS_B:  s_d.rdata = s_d.bus_b & bus_wake_pkg::MASK_BUS_B; // see [R6]
      bus_wake_pkg::ADDR_WAKE_I: s_d.rdata = s_d.wake_i & bus_wake_pkg::MASK_WAKE_I; // see [R6]
      bus_wake_pkg::ADDR_WAKE_E: s_d.rdata = s_d.wake_e & bus_wake_pkg::MASK_WAKE_E; // see [R6]
      default: begin
        s_d.rdata = 8'h00;
        s_d.hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      s_q <= '{bus_a:  bus_wake_pkg::RST_BUS_A,
               bus_b:  bus_wake_pkg::RST_BUS_B,
               wake_i: bus_wake_pkg::RST_WAKE_I,
               wake_e: bus_wake_pkg::RST_WAKE_E,
               rdata:  8'h00,
               hit:    1'b0,
               fail:   1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic meas;
  logic any_wake;

  assign rdata_o = s_q.rdata;
  assign addr_hit_o = s_q.hit;
  // a refused peak write in stop mode never counts as a failure
  assign write_fail_o = s_q.fail; // see [R10]

  // one setting drives both serial transceivers
  assign slope_control_off_o = s_q.bus_a[bus_wake_pkg::BIT_FLASH]; // see [R1] see [R7]
  assign low_slope_select_o = s_q.bus_a[bus_wake_pkg::BIT_LOW_SLOPE]; // see [R2] see [R7]
  assign tx_timeout_enable_o = s_q.bus_a[bus_wake_pkg::BIT_TX_TO]; // see [R3] see [R7]
  assign first_serial_bus_mode_o = s_q.bus_a[bus_wake_pkg::POS_SER_A +: 2]; // see [R4]
  assign can_mode_o = s_q.bus_a[bus_wake_pkg::POS_CAN +: 2]; // see [R5]
  assign second_serial_bus_mode_o = s_q.bus_b[bus_wake_pkg::POS_SER_B +: 2]; // see [R11]
  assign peak_current_threshold_select_o = s_q.bus_b[bus_wake_pkg::BIT_PEAK]; // see [R9]
  assign stop_watchdog_disable_hi_o = s_q.wake_i[bus_wake_pkg::BIT_WD_DIS_HI]; // see [R14]

  assign meas = s_q.wake_e[bus_wake_pkg::BIT_MEASURE];
  assign measure_active_o = meas && (dev_mode_i == bus_wake_pkg::DEV_NORMAL); // see [R17]
  assign wake_level_valid_o = {1'b1, ~meas, ~meas}; // see [R17]

  assign timer_wake_o = (timer_b_event_i && s_q.wake_i[bus_wake_pkg::BIT_TMR_B_WK]) // see [R12]
                     || (timer_a_event_i && s_q.wake_i[bus_wake_pkg::BIT_TMR_A_WK]); // see [R13]
  assign input_wake_o =
      (wake_input_event_i[2] && s_q.wake_e[bus_wake_pkg::BIT_WK_C]) // see [R18]
   || (wake_input_event_i[1] && s_q.wake_e[bus_wake_pkg::BIT_WK_B] && !meas) // see [R16]
   || (wake_input_event_i[0] && s_q.wake_e[bus_wake_pkg::BIT_WK_A] && !meas); // see [R16]

  assign any_wake = timer_wake_o || input_wake_o;
  assign interrupt_request_o = any_wake ||
      (status_event_i && s_q.wake_e[bus_wake_pkg::BIT_INT_GLOBAL]); // see [R15]

endmodule : bus_wake_ctrl

`default_nettype wire

// File: src/bus_wake_pkg.sv
// Purpose: constants for the bus and wake control register bank
// Assumes: 7-bit register addresses, 8-bit data
// Notes:   x in fail-safe/restart patterns means the bit keeps its value
package bus_wake_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_BUS_A  = 7'h04;
  localparam logic [6:0] ADDR_BUS_B  = 7'h05;
  localparam logic [6:0] ADDR_WAKE_I = 7'h06;
  localparam logic [6:0] ADDR_WAKE_E = 7'h07;

  // ---------------------------------------------------------------
  // reset values and writable-bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BUS_A  = 8'h20;
  localparam logic [7:0] RST_BUS_B  = 8'h00;
  localparam logic [7:0] RST_WAKE_I = 8'h00;
  localparam logic [7:0] RST_WAKE_E = 8'h07;

  localparam logic [7:0] MASK_BUS_A  = 8'hfb;
  localparam logic [7:0] MASK_BUS_B  = 8'h23;
  localparam logic [7:0] MASK_WAKE_I = 8'hc4;
  localparam logic [7:0] MASK_WAKE_E = 8'ha7;

  // ---------------------------------------------------------------
  // fail-safe patterns: keep bits where keep mask is 1
  // ---------------------------------------------------------------
  localparam logic [7:0] FS_BUS_A   = 8'h09;
  localparam logic [7:0] FS_KEEP_A  = 8'he0;
  localparam logic [7:0] FS_BUS_B   = 8'h01;
  localparam logic [7:0] FS_WAKE_E  = 8'h07;
  localparam logic [7:0] FS_KEEP_E  = 8'ha0;

  // restart of bus control a: upper option bits kept
  localparam logic [7:0] RS_KEEP_A  = 8'he0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_FLASH      = 7;
  localparam int BIT_LOW_SLOPE  = 6;
  localparam int BIT_TX_TO      = 5;
  localparam int POS_SER_A      = 3;
  localparam int POS_CAN        = 0;
  localparam int BIT_PEAK       = 5;
  localparam int POS_SER_B      = 0;
  localparam int BIT_TMR_B_WK   = 7;
  localparam int BIT_TMR_A_WK   = 6;
  localparam int BIT_WD_DIS_HI  = 2;
  localparam int BIT_INT_GLOBAL = 7;
  localparam int BIT_MEASURE    = 5;
  localparam int BIT_WK_C       = 2;
  localparam int BIT_WK_B       = 1;
  localparam int BIT_WK_A       = 0;

  // transceiver mode encoding
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_RX   = 2'h2;
  localparam logic [1:0] MODE_NORM = 2'h3;

  // device operating modes as presented by the mode controller
  typedef enum logic [1:0] {
    DEV_INIT, DEV_NORMAL, DEV_STOP, DEV_OTHER
  } dev_mode_t;

endpackage : bus_wake_pkg

// File: bench/bus_wake_ctrl_monitor.sv
// Purpose: assertion checker for the bus and wake control registers
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the ports of the register block
`timescale 1ns/10ps
`default_nettype none
module bus_wake_ctrl_monitor (
  input wire logic                    clock_i,
  input wire logic                    rstn_i,
  input wire logic                    soft_reset_i,
  input wire logic                    wr_i,
  input wire logic                    failsafe_entry_i,
  input wire logic                    restart_i,
  input wire logic                    hw_ser_a_we_i,
  input wire logic                    hw_can_we_i,
  input wire logic                    hw_ser_b_we_i,
  input wire logic                    timer_a_event_i,
  input wire logic                    timer_b_event_i,
  input wire logic [6:0]              addr_i,
  input wire logic [7:0]              wdata_i,
  input wire logic [7:0]              rdata_o,
  input wire logic [2:0]              wake_input_event_i,
  input wire logic [2:0]              wake_level_valid_o,
  input wire bus_wake_pkg::dev_mode_t dev_mode_i,
  input wire logic [1:0]              first_serial_bus_mode_o,
  input wire logic [1:0]              second_serial_bus_mode_o,
  input wire logic [1:0]              can_mode_o,
  input wire logic                    addr_hit_o,
  input wire logic                    slope_control_off_o,
  input wire logic                    low_slope_select_o,
  input wire logic                    tx_timeout_enable_o,
  input wire logic                    peak_current_threshold_select_o,
  input wire logic                    measure_active_o,
  input wire logic                    timer_wake_o,
  input wire logic                    input_wake_o,
  input wire logic                    interrupt_request_o
);
  localparam logic [3:0][7:0] MASKS = {bus_wake_pkg::MASK_WAKE_E, bus_wake_pkg::MASK_WAKE_I,
                                       bus_wake_pkg::MASK_BUS_B, bus_wake_pkg::MASK_BUS_A};
  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // higher-priority device updates would mask a host write
  wire quiet = !soft_reset_i && !failsafe_entry_i && !restart_i;
  sequence s_wr_a;
    wr_i && addr_i == bus_wake_pkg::ADDR_BUS_A && quiet && !hw_ser_a_we_i && !hw_can_we_i;
  endsequence
  sequence s_wr_b;
    wr_i && addr_i == bus_wake_pkg::ADDR_BUS_B && quiet && !hw_ser_b_we_i;
  endsequence
  a_option_bits: assert property (wr_i && quiet &&
    addr_i == bus_wake_pkg::ADDR_BUS_A |=>
    {slope_control_off_o, low_slope_select_o, tx_timeout_enable_o} == $past(wdata_i[7:5]))
    else $error("option bits differ from write");
  a_bus_a_readback: assert property (s_wr_a |=> rdata_o == ($past(wdata_i) & 8'hfb)
    && first_serial_bus_mode_o == $past(wdata_i[4:3]) && can_mode_o == $past(wdata_i[1:0]))
    else $error("bus control a write not stored");
  a_ser_b_mode: assert property (s_wr_b |=> second_serial_bus_mode_o == $past(wdata_i[1:0]))
    else $error("second bus mode not stored");
  a_reserved_zero: assert property (addr_hit_o |-> (rdata_o & ~MASKS[$past(addr_i[1:0])]) == 0)
    else $error("reserved bit reads one");
  a_peak_stop_lock: assert property (dev_mode_i == bus_wake_pkg::DEV_STOP && !failsafe_entry_i
    && !soft_reset_i |=> $stable(peak_current_threshold_select_o))
    else $error("peak bit changed in stop mode");
  a_failsafe_force: assert property (failsafe_entry_i && !soft_reset_i |=>
    !peak_current_threshold_select_o
    && {first_serial_bus_mode_o, can_mode_o, second_serial_bus_mode_o} == 6'h15)
    else $error("fail-safe values not forced");
  a_measure_gate: assert property (measure_active_o |-> wake_level_valid_o[1:0] == 2'h0)
    else $error("level status valid while measuring");
  a_measure_wake: assert property (measure_active_o && !wake_input_event_i[2] |-> !input_wake_o)
    else $error("wake input a or b woke while measuring");
  a_timer_gate: assert property (wr_i && !soft_reset_i &&
    addr_i == bus_wake_pkg::ADDR_WAKE_I |=> timer_wake_o ==
    (($past(wdata_i[6]) && timer_a_event_i) || ($past(wdata_i[7]) && timer_b_event_i)))
    else $error("timer wake disagrees with enables");
  a_wake_interrupt: assert property (input_wake_o || timer_wake_o |-> interrupt_request_o)
    else $error("wake without interrupt");
endmodule : bus_wake_ctrl_monitor
bind bus_wake_ctrl bus_wake_ctrl_monitor u_bus_wake_ctrl_monitor (.*);
`default_nettype wire

// File: bench/host_model.sv
// Purpose: host side of the register access port
// Assumes: one access per call, driven at the falling edge
// Notes:   released data shows inverted, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       wr_o,
  output var  logic [6:0] addr_o,
  output var  logic [7:0] wdata_o
);
  initial begin
    {wr_o, addr_o, wdata_o} = '0;
  end
  task automatic write(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clock_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : write
  task automatic read(input logic [6:0] a, output logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    @(negedge clock_i);
    d = rdata_i;
  endtask : read
endmodule : host_model
`default_nettype wire

// File: bench/bus_wake_ctrl_test.sv
// Purpose: directed bench for the bus and wake control registers
// Assumes: host model owns the access port, bench owns device inputs
// Notes:   wake level inputs tied low, the block ignores them
`timescale 1ns/10ps
`default_nettype none
`define CHECK_EQ(act, exp) begin checked++; if ((act) !== (exp)) begin miscompares++; \
  $display("mismatch t=%0t act=%h exp=%h", $time, (act), (exp)); end end
module bus_wake_ctrl_test;
  logic clock_i, rstn_i, soft_reset_i, wr_i, failsafe_entry_i, restart_i, hw_ser_a_we_i;
  logic hw_can_we_i, hw_ser_b_we_i, hw_wd_dis_we_i, hw_wd_dis_i, timer_a_event_i, timer_b_event_i;
  logic status_event_i, addr_hit_o, write_fail_o, slope_control_off_o, low_slope_select_o;
  logic tx_timeout_enable_o, peak_current_threshold_select_o, stop_watchdog_disable_hi_o;
  logic measure_active_o, timer_wake_o, input_wake_o, interrupt_request_o;
  logic [1:0] restart_ser_a_mode_i, restart_can_mode_i, restart_ser_b_mode_i, hw_ser_a_mode_i;
  logic [1:0] hw_can_mode_i, hw_ser_b_mode_i, first_serial_bus_mode_o, second_serial_bus_mode_o;
  logic [1:0] can_mode_o, hw_mode, tmr;
  logic [2:0] wake_input_event_i, wake_level_i, wake_level_valid_o;
  logic [5:0] rs_modes;
  logic [6:0] addr_i, pulses;
  logic [7:0] wdata_i, rdata_o;
  bus_wake_pkg::dev_mode_t dev_mode_i;
  int miscompares = 0;
  int checked = 0;
  assign {hw_ser_b_we_i, hw_can_we_i, hw_ser_a_we_i, hw_wd_dis_we_i, restart_i, failsafe_entry_i,
          soft_reset_i} = pulses;
  assign {hw_ser_a_mode_i, hw_can_mode_i, hw_ser_b_mode_i, hw_wd_dis_i} = {{3{hw_mode}}, hw_mode[1]};
  assign {restart_ser_a_mode_i, restart_can_mode_i, restart_ser_b_mode_i} = rs_modes;
  assign {timer_b_event_i, timer_a_event_i} = tmr;
  assign wake_level_i = 3'h0;
  bus_wake_ctrl u_bus_wake_ctrl (.*);
  host_model u_host_model (.clock_i(clock_i), .rdata_i(rdata_o), .wr_o(wr_i), .addr_o(addr_i),
                           .wdata_o(wdata_i));
  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host_model.read(a, d);
    `CHECK_EQ(d, e)
  endtask : rd
  task automatic wr4(input logic [31:0] v);
    for (int i = 0; i < 4; i++) u_host_model.write(7'h04 + 7'(i), v[8*i +: 8]);
  endtask : wr4
  task automatic rd4(input logic [31:0] v);
    for (int i = 0; i < 4; i++) rd(7'h04 + 7'(i), v[8*i +: 8]);
  endtask : rd4
  task automatic pulse(input logic [6:0] p);
    @(negedge clock_i);
    pulses = p;
    @(negedge clock_i);
    pulses = 7'h00;
  endtask : pulse
  task automatic complete_run();
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    // about 130 cycles expected, generous margin
    #200us;
    miscompares++;
    complete_run();
  end
  initial begin
    {rstn_i, status_event_i, pulses, tmr, wake_input_event_i, hw_mode, rs_modes} = '0;
    dev_mode_i = bus_wake_pkg::DEV_NORMAL;
    repeat (12) @(negedge clock_i);
    rstn_i = 1'b1;
    rd4(32'h07000020);
    rd(7'h08, 8'h00);
    `CHECK_EQ(addr_hit_o, 1'b0)
    wr4(32'hffffffff);
    rd4(32'ha7c423fb);
    `CHECK_EQ({slope_control_off_o, low_slope_select_o}, 2'h3)
    `CHECK_EQ(tx_timeout_enable_o, 1'b1)
    for (int m = 0; m < 4; m++) begin
      u_host_model.write(7'h04, {3'h0, 2'(m), 1'b0, 2'(m)});
      u_host_model.write(7'h05, {6'h00, 2'(m)});
      `CHECK_EQ({first_serial_bus_mode_o, can_mode_o}, {2{2'(m)}})
      `CHECK_EQ(second_serial_bus_mode_o, 2'(m))
      `CHECK_EQ({slope_control_off_o, low_slope_select_o, tx_timeout_enable_o}, 3'h0)
    end
    u_host_model.write(7'h05, 8'h20);
    `CHECK_EQ(peak_current_threshold_select_o, 1'b1)
    dev_mode_i = bus_wake_pkg::DEV_STOP;
    u_host_model.write(7'h05, 8'h02);
    `CHECK_EQ({peak_current_threshold_select_o, write_fail_o}, 2'h2)
    dev_mode_i = bus_wake_pkg::DEV_INIT;
    u_host_model.write(7'h05, 8'h00);
    rd(7'h05, 8'h00);
    dev_mode_i = bus_wake_pkg::DEV_NORMAL;
    for (int i = 0; i < 3; i++) begin
      u_host_model.write(7'h07, 8'h01 << i);
      u_host_model.write(7'h06, 8'h40 << i);
      wake_input_event_i = ~(3'h1 << i);
      tmr = ~(2'h1 << i);
      #1 `CHECK_EQ({input_wake_o, timer_wake_o}, 2'h0)
      `CHECK_EQ(interrupt_request_o, 1'b0)
      @(negedge clock_i);
      wake_input_event_i = 3'h1 << i;
      tmr = 2'h1 << i;
      #1 `CHECK_EQ({input_wake_o, timer_wake_o}, {1'b1, 1'(i < 2)})
      `CHECK_EQ(interrupt_request_o, 1'b1)
    end
    u_host_model.write(7'h07, 8'h27);
    wake_input_event_i = 3'h3;
    #1 `CHECK_EQ({input_wake_o, measure_active_o, wake_level_valid_o}, 5'h0c)
    @(negedge clock_i);
    wake_input_event_i = 3'h0;
    status_event_i = 1'b1;
    #1 `CHECK_EQ(interrupt_request_o, 1'b0)
    u_host_model.write(7'h07, 8'ha7);
    `CHECK_EQ(interrupt_request_o, 1'b1)
    status_event_i = 1'b0;
    hw_mode = 2'h2;
    pulse(7'h78);
    `CHECK_EQ(stop_watchdog_disable_hi_o, 1'b1)
    rd4(32'ha7040212);
    wr4(32'ha00423e7);
    pulse(7'h02);
    rd4(32'ha70401e9);
    u_host_model.write(7'h05, 8'h21);
    rs_modes = 6'h2e;
    pulse(7'h04);
    rd(7'h04, 8'hf3);
    rd(7'h05, 8'h22);
    pulse(7'h01);
    rd4(32'h07000020);
    complete_run();
  end
endmodule : bus_wake_ctrl_test
`default_nettype wire
